// ### srxd_cfg.svh
// constants of the shift, rotate, subtract and exclusive-or decoder
`ifndef SRXD_CFG_SVH
`define SRXD_CFG_SVH

// prefix bytes
`define SRXD_PFX_BIT        8'hCB
`define SRXD_PFX_EXT        8'hED
`define SRXD_PFX_IDX_FIRST  8'hDD
`define SRXD_PFX_IDX_SECOND 8'hFD

// whole opcode bytes
`define SRXD_OPC_SUB_MEM       8'h96
`define SRXD_OPC_SBC_MEM       8'h9E
`define SRXD_OPC_XOR_MEM       8'hAE
`define SRXD_OPC_SBC_IMM       8'hDE
`define SRXD_OPC_SUB_IMM       8'hD6
`define SRXD_OPC_XOR_IMM       8'hEE
`define SRXD_OPC_ACC_ROT_THRU  8'h1F
`define SRXD_OPC_ACC_ROT_CIRC  8'h0F
`define SRXD_OPC_CARRY_ONE     8'h37
`define SRXD_OPC_SRL_MEM       8'h3E

// upper five bits of grouped opcodes
`define SRXD_GRP_ROT_CIRC  5'h01
`define SRXD_GRP_ROT_THRU  5'h03
`define SRXD_GRP_SHL_ARITH 5'h04
`define SRXD_GRP_SHR_ARITH 5'h05
`define SRXD_GRP_SHR_LOGIC 5'h07
`define SRXD_GRP_SUB_REG   5'h12
`define SRXD_GRP_SBC_REG   5'h13
`define SRXD_GRP_XOR_REG   5'h15

// other field patterns
`define SRXD_TOP2_SET     2'h3
`define SRXD_TOP2_RST     2'h3
`define SRXD_LOW3_RST     3'h7
`define SRXD_SEL_MEM      3'h6
`define SRXD_TOP2_PAIR16  2'h1
`define SRXD_LOW4_PAIR16  4'h2
`define SRXD_VEC_LEGAL    8'hBC

// field positions
`define SRXD_R_MSB    2
`define SRXD_R_LSB    0
`define SRXD_B_MSB    5
`define SRXD_B_LSB    3
`define SRXD_SS_MSB   5
`define SRXD_SS_LSB   4
`define SRXD_TOP5_LSB 3
`define SRXD_TOP2_LSB 6
`define SRXD_LOW4_MSB 3

// clock counts per form
`define SRXD_CLK_REG_BIT 4'h4
`define SRXD_CLK_MEM_BIT 4'hA
`define SRXD_CLK_IDX_BIT 4'hD
`define SRXD_CLK_REG_ALU 4'h2
`define SRXD_CLK_MEM_ALU 4'h5
`define SRXD_CLK_IDX_ALU 4'h9
`define SRXD_CLK_IMM     4'h4
`define SRXD_CLK_RESTART 4'h8
`define SRXD_CLK_PAIR16  4'h4
`define SRXD_CLK_SHORT   4'h2

`endif

// ### srxd_decoder.sv
// decoder for rotate, shift, subtract, bit-set, exclusive-or and restart
`timescale 1ns/1ps
`include "srxd_cfg.svh"

// Contract
// RULE1: CB 00011rrr rotate through carry, 4 clocks
// RULE2: CB 0E circular rotate memory, 10, writeback
// RULE3: CB 00001rrr register circular rotate, 4 clocks
// RULE4: restart 11vvv111, vectors 2,3,4,5,7, 8 clocks
// RULE5: ED 01ss0010 pair subtract-borrow, 4, flags
// RULE6: DE plus immediate subtract-borrow, 4 clocks
// RULE7: CB 11bbb110 memory bit set, 10 clocks
// RULE8: CB 26 memory arithmetic shift left, 10
// RULE9: CB 00100rrr register shift left, 4 clocks
// RULE10: CB 2E memory sign shift right, 10
// RULE11: CB 00101rrr register sign shift right, 4
// RULE12: CB 3E memory logical shift right, 10
// RULE13: DD CB d 3E indexed logical shift, 13
// RULE14: CB 00111rrr register logical shift right, 4
// RULE15: 96 memory subtract, 5 clocks
// RULE16: DD 96 d indexed subtract, 9 clocks
// RULE17: FD selects second index, same timing
// RULE18: D6 plus immediate subtract, 4 clocks
// RULE19: DD AE d indexed xor, 9, logic flags
// RULE20: EE plus immediate xor, 4 clocks
// RULE21: one fixed register and pair encoding
module srxd_decoder #(
  parameter int CLK_W = 4
) (
  input  wire logic                ref_clk,
  input  wire logic                arst_n,
  input  wire logic                byte_valid,
  input  wire logic [7:0]          byte_data,
  output logic                     byte_ready,
  output logic                     dec_valid,
  output logic                     dec_illegal,
  output srxd_pkg::srxd_op_t       dec_op,
  output srxd_pkg::srxd_opnd_t     dec_opnd,
  output srxd_pkg::srxd_idx_t      dec_index,
  output srxd_pkg::srxd_reg_t      dec_reg,
  output srxd_pkg::srxd_pair_t     dec_pair,
  output srxd_pkg::srxd_flag_t     dec_flags,
  output logic                     dec_mem_wb,
  output logic [2:0]               dec_bit,
  output logic [7:0]               dec_disp,
  output logic [7:0]               dec_imm,
  output logic [CLK_W-1:0]         dec_clocks
);
  import srxd_pkg::*;

  if (CLK_W < 4) begin : g_bad_width
    $error("CLK_W must hold a count of 13");
  end

  srxd_state_t  state_r, state_nxt;
  srxd_idx_t    idx_r, idx_nxt;
  logic [7:0]   hold_r, hold_nxt;
  logic [7:0]   disp_r, disp_nxt;
  logic [1:0]   cnt_r, cnt_nxt;
  logic         ready_r, ready_nxt;
  logic         valid_r, valid_nxt;
  logic         illegal_r, illegal_nxt;
  srxd_op_t     op_r, op_nxt;
  srxd_opnd_t   opnd_r, opnd_nxt;
  srxd_idx_t    oidx_r, oidx_nxt;
  srxd_reg_t    reg_r, reg_nxt;
  srxd_pair_t   pair_r, pair_nxt;
  srxd_flag_t   flag_r, flag_nxt;
  logic         wb_r, wb_nxt;
  logic [2:0]   bit_r, bit_nxt;
  logic [7:0]   odisp_r, odisp_nxt;
  logic [7:0]   imm_r, imm_nxt;
  logic [CLK_W-1:0] clk_r, clk_nxt;

  // one bit per restart vector, set where the vector is served
  localparam logic [7:0] VEC_LEGAL = `SRXD_VEC_LEGAL;

  logic         take;
  logic         fin;
  logic         bad;
  logic [7:0]   cls_byte;
  logic         cls_bit;
  logic         cls_idx;
  logic         cls_mem;
  srxd_op_t     c_op;
  srxd_opnd_t   c_opnd;
  srxd_flag_t   c_flag;
  logic [3:0]   c_clk;
  logic         c_wb;
  logic         c_ok;
  logic [3:0]   stall;
  logic         tmr_load;
  logic         tmr_last;
  srxd_reg_t    map_reg;
  srxd_pair_t   map_pair;

  assign take     = byte_valid && ready_r;
  assign cls_byte = (state_r == ST_IMM || state_r == ST_IDX_DISP) ? hold_r : byte_data;
  assign cls_bit  = (state_r == ST_BIT) || (state_r == ST_IDXBIT_OP);
  assign cls_idx  = (idx_r != IDX_NONE);
  assign cls_mem  = (cls_byte[`SRXD_R_MSB:`SRXD_R_LSB] == `SRXD_SEL_MEM);

  srxd_field_map u_map (
    .r_code   (cls_byte[`SRXD_R_MSB:`SRXD_R_LSB]),
    .ss_code  (cls_byte[`SRXD_SS_MSB:`SRXD_SS_LSB]),
    .reg_sel  (map_reg),
    .pair_sel (map_pair)
  );

  // classify the opcode byte (hold_r while an immediate or displacement arrives) in the current context
  always_comb begin
    c_op   = OP_NONE;
    c_opnd = OPND_NONE;
    c_flag = FLG_NONE;
    c_clk  = `SRXD_CLK_SHORT;
    c_wb   = 1'b0;
    c_ok   = 1'b1;
    if (state_r == ST_EXT) begin
      c_ok   = (cls_byte[7:`SRXD_TOP2_LSB] == `SRXD_TOP2_PAIR16) &&
               (cls_byte[`SRXD_LOW4_MSB:0] == `SRXD_LOW4_PAIR16);               // RULE5
      c_op   = OP_SUB_BORROW16;
      c_opnd = OPND_PAIR16;
      c_flag = FLG_ARITH;
      c_clk  = `SRXD_CLK_PAIR16;
    end else if (cls_bit) begin
      c_wb   = cls_mem;
      c_flag = FLG_SHIFT;
      c_opnd = cls_idx ? OPND_INDEXED : (cls_mem ? OPND_MEM_PAIR : OPND_REG);
      c_clk  = cls_idx ? `SRXD_CLK_IDX_BIT
             : (cls_mem ? `SRXD_CLK_MEM_BIT : `SRXD_CLK_REG_BIT);                // RULE2 RULE13
      if (cls_byte[7:`SRXD_TOP2_LSB] == `SRXD_TOP2_SET) begin
        c_op   = OP_BIT_SET;                                                      // RULE7
        c_flag = FLG_NONE;
      end else begin
        case (cls_byte[7:`SRXD_TOP5_LSB])
          `SRXD_GRP_ROT_THRU:  c_op = OP_ROT_THRU;                                // RULE1
          `SRXD_GRP_ROT_CIRC:  c_op = OP_ROT_CIRC;                                // RULE3
          `SRXD_GRP_SHL_ARITH: c_op = OP_SHL_ARITH;                               // RULE8 RULE9
          `SRXD_GRP_SHR_ARITH: c_op = OP_SHR_ARITH;                               // RULE10 RULE11
          `SRXD_GRP_SHR_LOGIC: c_op = OP_SHR_LOGIC;                               // RULE12 RULE14
          default:             c_ok = 1'b0;
        endcase
      end
      if (cls_idx && !cls_mem) begin
        c_ok = 1'b0;
      end
    end else if (cls_byte == `SRXD_OPC_SUB_MEM || cls_byte == `SRXD_OPC_SBC_MEM ||
                 cls_byte == `SRXD_OPC_XOR_MEM) begin
      c_op   = (cls_byte == `SRXD_OPC_SUB_MEM) ? OP_SUB
             : ((cls_byte == `SRXD_OPC_SBC_MEM) ? OP_SUB_BORROW : OP_XOR);
      c_flag = (c_op == OP_XOR) ? FLG_LOGIC : FLG_ARITH;                          // RULE19
      c_opnd = cls_idx ? OPND_INDEXED : OPND_MEM_PAIR;
      c_clk  = cls_idx ? `SRXD_CLK_IDX_ALU : `SRXD_CLK_MEM_ALU;                   // RULE15 RULE16
    end else if (cls_idx) begin
      c_ok = 1'b0;
    end else if (cls_byte == `SRXD_OPC_SBC_IMM || cls_byte == `SRXD_OPC_SUB_IMM ||
                 cls_byte == `SRXD_OPC_XOR_IMM) begin
      c_op   = (cls_byte == `SRXD_OPC_SUB_IMM) ? OP_SUB
             : ((cls_byte == `SRXD_OPC_SBC_IMM) ? OP_SUB_BORROW : OP_XOR);       // RULE6 RULE18 RULE20
      c_flag = (c_op == OP_XOR) ? FLG_LOGIC : FLG_ARITH;
      c_opnd = OPND_IMM;
      c_clk  = `SRXD_CLK_IMM;
    end else if (cls_byte[7:`SRXD_TOP2_LSB] == `SRXD_TOP2_RST &&
                 cls_byte[`SRXD_R_MSB:`SRXD_R_LSB] == `SRXD_LOW3_RST) begin
      c_op  = OP_RESTART;
      c_clk = `SRXD_CLK_RESTART;
      c_ok  = VEC_LEGAL[cls_byte[`SRXD_B_MSB:`SRXD_B_LSB]];                      // RULE4
    end else if (cls_byte == `SRXD_OPC_ACC_ROT_THRU) begin
      c_op   = OP_ACC_ROT_THRU;
      c_flag = FLG_SHIFT;
    end else if (cls_byte == `SRXD_OPC_ACC_ROT_CIRC) begin
      c_op   = OP_ACC_ROT_CIRC;
      c_flag = FLG_SHIFT;
    end else if (cls_byte == `SRXD_OPC_CARRY_ONE) begin
      c_op   = OP_CARRY_ONE;
      c_flag = FLG_CARRY_ONE;
    end else begin
      c_opnd = OPND_REG;
      c_flag = FLG_ARITH;
      case (cls_byte[7:`SRXD_TOP5_LSB])
        `SRXD_GRP_SUB_REG: c_op = OP_SUB;
        `SRXD_GRP_SBC_REG: c_op = OP_SUB_BORROW;
        `SRXD_GRP_XOR_REG: begin
          c_op   = OP_XOR;
          c_flag = FLG_LOGIC;
        end
        default:           c_ok = 1'b0;
      endcase
    end
  end

  // byte sequencer
  always_comb begin
    state_nxt = state_r;
    idx_nxt   = idx_r;
    hold_nxt  = hold_r;
    disp_nxt  = disp_r;
    cnt_nxt   = cnt_r;
    fin       = 1'b0;
    bad       = 1'b0;
    if (take) begin
      cnt_nxt = cnt_r + 2'h1;
      case (state_r)
        ST_OP: begin
          if (byte_data == `SRXD_PFX_BIT) begin
            state_nxt = ST_BIT;
          end else if (byte_data == `SRXD_PFX_EXT) begin
            state_nxt = ST_EXT;
          end else if (byte_data == `SRXD_PFX_IDX_FIRST) begin
            state_nxt = ST_IDX;
            idx_nxt   = IDX_FIRST;                                                // RULE16
          end else if (byte_data == `SRXD_PFX_IDX_SECOND) begin
            state_nxt = ST_IDX;
            idx_nxt   = IDX_SECOND;                                               // RULE17
          end else if (c_ok && c_opnd == OPND_IMM) begin
            hold_nxt  = byte_data;
            state_nxt = ST_IMM;
          end else begin
            fin = c_ok;
            bad = !c_ok;
          end
        end
        ST_IDX: begin
          if (byte_data == `SRXD_PFX_BIT) begin
            state_nxt = ST_IDXBIT_DISP;                                           // RULE13
          end else if (c_ok) begin
            hold_nxt  = byte_data;
            state_nxt = ST_IDX_DISP;
          end else begin
            bad = 1'b1;
          end
        end
        ST_IDXBIT_DISP: begin
          disp_nxt  = byte_data;
          state_nxt = ST_IDXBIT_OP;
        end
        ST_IDX_DISP, ST_IMM: begin
          fin = 1'b1;
        end
        ST_BIT, ST_EXT, ST_IDXBIT_OP: begin
          fin = c_ok;
          bad = !c_ok;
        end
        default: begin
          bad = 1'b1;
        end
      endcase
      if (fin || bad) begin
        state_nxt = ST_OP;
        idx_nxt   = IDX_NONE;
        cnt_nxt   = 2'h0;
      end
    end
  end

  // clocks left after one per fetched byte
  assign stall    = c_clk - {2'h0, cnt_r} - 4'h1;
  assign tmr_load = fin && (stall != 4'h0);

  srxd_stall_timer #(
    .W (4)
  ) u_timer (
    .ref_clk  (ref_clk),
    .arst_n   (arst_n),
    .load     (tmr_load),
    .load_cnt (stall),
    .last     (tmr_last)
  );

  // decoded result, held until the next legal instruction is decoded
  always_comb begin
    ready_nxt   = tmr_load ? 1'b0 : (tmr_last ? 1'b1 : ready_r);
    valid_nxt   = fin;
    illegal_nxt = bad;
    op_nxt      = op_r;
    opnd_nxt    = opnd_r;
    oidx_nxt    = oidx_r;
    reg_nxt     = reg_r;
    pair_nxt    = pair_r;
    flag_nxt    = flag_r;
    wb_nxt      = wb_r;
    bit_nxt     = bit_r;
    odisp_nxt   = odisp_r;
    imm_nxt     = imm_r;
    clk_nxt     = clk_r;
    if (fin) begin
      op_nxt    = c_op;
      opnd_nxt  = c_opnd;
      oidx_nxt  = idx_r;                                                          // RULE17
      reg_nxt   = map_reg;                                                        // RULE21
      pair_nxt  = map_pair;                                                       // RULE21
      flag_nxt  = c_flag;
      wb_nxt    = c_wb;
      bit_nxt   = cls_byte[`SRXD_B_MSB:`SRXD_B_LSB];
      odisp_nxt = (state_r == ST_IDX_DISP) ? byte_data : disp_r;
      imm_nxt   = byte_data;
      clk_nxt   = CLK_W'(c_clk);
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r   <= ST_OP;
      idx_r     <= IDX_NONE;
      hold_r    <= 8'h00;
      disp_r    <= 8'h00;
      cnt_r     <= 2'h0;
      ready_r   <= 1'b1;
      valid_r   <= 1'b0;
      illegal_r <= 1'b0;
      op_r      <= OP_NONE;
      opnd_r    <= OPND_NONE;
      oidx_r    <= IDX_NONE;
      reg_r     <= REG_B;
      pair_r    <= PAIR_BC;
      flag_r    <= FLG_NONE;
      wb_r      <= 1'b0;
      bit_r     <= 3'h0;
      odisp_r   <= 8'h00;
      imm_r     <= 8'h00;
      clk_r     <= '0;
    end else begin
      state_r   <= state_nxt;
      idx_r     <= idx_nxt;
      hold_r    <= hold_nxt;
      disp_r    <= disp_nxt;
      cnt_r     <= cnt_nxt;
      ready_r   <= ready_nxt;
      valid_r   <= valid_nxt;
      illegal_r <= illegal_nxt;
      op_r      <= op_nxt;
      opnd_r    <= opnd_nxt;
      oidx_r    <= oidx_nxt;
      reg_r     <= reg_nxt;
      pair_r    <= pair_nxt;
      flag_r    <= flag_nxt;
      wb_r      <= wb_nxt;
      bit_r     <= bit_nxt;
      odisp_r   <= odisp_nxt;
      imm_r     <= imm_nxt;
      clk_r     <= clk_nxt;
    end
  end

  assign byte_ready  = ready_r;
  assign dec_valid   = valid_r;
  assign dec_illegal = illegal_r;
  assign dec_op      = op_r;
  assign dec_opnd    = opnd_r;
  assign dec_index   = oidx_r;
  assign dec_reg     = reg_r;
  assign dec_pair    = pair_r;
  assign dec_flags   = flag_r;
  assign dec_mem_wb  = wb_r;
  assign dec_bit     = bit_r;
  assign dec_disp    = odisp_r;
  assign dec_imm     = imm_r;
  assign dec_clocks  = clk_r;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  a_rot_thru_timing: assert property (                                           // RULE1
    dec_valid && dec_op == OP_ROT_THRU && dec_opnd == OPND_REG |->
    dec_clocks == CLK_W'(4) && !byte_ready ##1 !byte_ready ##1 byte_ready)
    else $error("register rotate through carry timing wrong");
  a_circ_mem_wb: assert property (                                               // RULE2
    dec_valid && dec_op == OP_ROT_CIRC && dec_opnd == OPND_MEM_PAIR |->
    dec_clocks == CLK_W'(10) && dec_mem_wb)
    else $error("memory circular rotate timing or writeback wrong");
  a_reg_shift_clocks: assert property (                                          // RULE3
    dec_valid && dec_opnd == OPND_REG && (dec_op == OP_ROT_CIRC ||
    dec_op == OP_SHL_ARITH || dec_op == OP_SHR_ARITH || dec_op == OP_SHR_LOGIC) |->
    dec_clocks == CLK_W'(4) && !dec_mem_wb)
    else $error("register shift clocks wrong");
  a_restart_vector: assert property (                                            // RULE4
    dec_valid && dec_op == OP_RESTART |->
    dec_bit inside {3'h2, 3'h3, 3'h4, 3'h5, 3'h7} && dec_clocks == CLK_W'(8)
    ##0 !byte_ready[*7] ##1 byte_ready)
    else $error("restart vector or timing wrong");
  a_pair_sub_flags: assert property (                                            // RULE5
    dec_valid && dec_op == OP_SUB_BORROW16 |->
    dec_clocks == CLK_W'(4) && dec_flags == FLG_ARITH && dec_opnd == OPND_PAIR16)
    else $error("pair subtract decode wrong");
  a_imm_operand: assert property (                                               // RULE6
    dec_valid && dec_opnd == OPND_IMM |->
    dec_clocks == CLK_W'(4) && dec_imm == $past(byte_data))
    else $error("immediate operand wrong");
  a_bit_set_select: assert property (                                            // RULE7
    dec_valid && dec_op == OP_BIT_SET && dec_opnd == OPND_MEM_PAIR |->
    dec_clocks == CLK_W'(10) && dec_bit == $past(byte_data[5:3]))
    else $error("memory bit set decode wrong");
  a_idx_shift_seq: assert property (                                             // RULE13
    dec_valid && dec_op == OP_SHR_LOGIC && dec_opnd == OPND_INDEXED |->
    dec_clocks == CLK_W'(13) && $past(byte_data) == `SRXD_OPC_SRL_MEM &&
    dec_index != IDX_NONE)
    else $error("indexed logical shift decode wrong");
  a_sub_mem_clocks: assert property (                                            // RULE15
    dec_valid && dec_op == OP_SUB |->
    (dec_opnd == OPND_MEM_PAIR) == (dec_clocks == CLK_W'(5)) &&
    (dec_opnd == OPND_INDEXED) == (dec_clocks == CLK_W'(9)))
    else $error("subtract clocks wrong");
  a_idx_xor_logic: assert property (                                             // RULE19
    dec_valid && dec_op == OP_XOR && dec_opnd == OPND_INDEXED |->
    dec_clocks == CLK_W'(9) && dec_flags == FLG_LOGIC &&
    dec_disp == $past(byte_data))
    else $error("indexed xor decode wrong");
  a_reg_code_acc: assert property (                                              // RULE21
    dec_valid && dec_opnd == OPND_REG && $past(byte_data[2:0]) == 3'h7 |->
    dec_reg == REG_A)
    else $error("register select encoding wrong");
  a_valid_excl: assert property (
    !(dec_valid && dec_illegal))
    else $error("decode and illegal together");

  c_idx_second: cover property (dec_valid && dec_index == IDX_SECOND);
  c_idx_bit: cover property (dec_valid && dec_opnd == OPND_INDEXED && dec_mem_wb);
  c_restart: cover property (dec_valid && dec_op == OP_RESTART);
  c_illegal: cover property (dec_illegal);
endmodule

// ### srxd_fetch_model.sv
// opcode-byte fetch model that offers queued bytes to the decoder
`timescale 1ns/1ps
module srxd_fetch_model (
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic       byte_ready,
  input  wire logic [3:0] gap,
  output logic            byte_valid,
  output logic [7:0]      byte_data
);
  logic [7:0] q[$];
  int         hold;
  task automatic push(input logic [7:0] b);
    q.push_back(b);
  endtask
  // offer held until taken; data scrambled while idle
  always @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      byte_valid <= 1'b0;
      byte_data  <= 8'h00;
      hold = 0;
    end else begin
      if (hold > 0) hold--;
      if (byte_valid && byte_ready) begin
        void'(q.pop_front());
        hold = gap;
      end
      if (q.size() > 0 && hold == 0) begin
        byte_valid <= 1'b1;
        byte_data  <= q[0];
      end else begin
        byte_valid <= 1'b0;
        byte_data  <= ~byte_data;
      end
    end
  end
endmodule

// ### srxd_field_map.sv
// fixed register and register-pair select encodings
`timescale 1ns/1ps
module srxd_field_map (
  input  wire logic [2:0]          r_code,
  input  wire logic [1:0]          ss_code,
  output srxd_pkg::srxd_reg_t      reg_sel,
  output srxd_pkg::srxd_pair_t     pair_sel
);
  import srxd_pkg::*;

  always_comb begin
    case (r_code)
      3'h0:    reg_sel = REG_B;
      3'h1:    reg_sel = REG_C;
      3'h2:    reg_sel = REG_D;
      3'h3:    reg_sel = REG_E;
      3'h4:    reg_sel = REG_H;
      3'h5:    reg_sel = REG_L;
      3'h6:    reg_sel = REG_MEM;
      default: reg_sel = REG_A;
    endcase
    case (ss_code)
      2'h0:    pair_sel = PAIR_BC;
      2'h1:    pair_sel = PAIR_DE;
      2'h2:    pair_sel = PAIR_PTR;
      default: pair_sel = PAIR_SP;
    endcase
  end
endmodule

// ### srxd_pkg.sv
// types of the shift, rotate, subtract and exclusive-or decoder
package srxd_pkg;
  typedef enum logic [3:0] {
    OP_NONE, OP_ROT_THRU, OP_ROT_CIRC, OP_ACC_ROT_THRU, OP_ACC_ROT_CIRC,
    OP_SHL_ARITH, OP_SHR_ARITH, OP_SHR_LOGIC, OP_BIT_SET, OP_RESTART,
    OP_SUB, OP_SUB_BORROW, OP_SUB_BORROW16, OP_XOR, OP_CARRY_ONE
  } srxd_op_t;
  typedef enum logic [2:0] {
    OPND_NONE, OPND_REG, OPND_MEM_PAIR, OPND_IMM, OPND_INDEXED, OPND_PAIR16
  } srxd_opnd_t;
  typedef enum logic [1:0] {IDX_NONE, IDX_FIRST, IDX_SECOND} srxd_idx_t;
  typedef enum logic [2:0] {
    FLG_NONE, FLG_ARITH, FLG_LOGIC, FLG_SHIFT, FLG_CARRY_ONE
  } srxd_flag_t;
  typedef enum logic [2:0] {
    REG_B, REG_C, REG_D, REG_E, REG_H, REG_L, REG_MEM, REG_A
  } srxd_reg_t;
  typedef enum logic [1:0] {PAIR_BC, PAIR_DE, PAIR_PTR, PAIR_SP} srxd_pair_t;
  typedef enum logic [2:0] {
    ST_OP, ST_BIT, ST_EXT, ST_IDX, ST_IDX_DISP, ST_IDXBIT_DISP, ST_IDXBIT_OP, ST_IMM
  } srxd_state_t;
endpackage

// ### srxd_stall_timer.sv
// countdown that holds off fetch for the remaining clocks of an instruction
`timescale 1ns/1ps
module srxd_stall_timer #(
  parameter int W = 4
) (
  input  wire logic         ref_clk,
  input  wire logic         arst_n,
  input  wire logic         load,
  input  wire logic [W-1:0] load_cnt,
  output logic              last
);
  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;

  always_comb begin
    if (load) begin
      count_nxt = load_cnt;
    end else if (count_r != '0) begin
      count_nxt = count_r - W'(1);
    end else begin
      count_nxt = count_r;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign last = (count_r == W'(1));
endmodule

// ### tb_shift_rotate_sub_xor_decoder.sv
// self-checking bench for the shift, rotate, subtract and exclusive-or decoder
`timescale 1ns/1ps
module tb_shift_rotate_sub_xor_decoder;
  import srxd_pkg::*;
  logic       ref_clk;
  logic       arst_n;
  logic [3:0] gap;
  logic       byte_valid;
  logic [7:0] byte_data;
  logic       byte_ready;
  logic       dec_valid;
  logic       dec_illegal;
  srxd_op_t   dec_op;
  srxd_opnd_t dec_opnd;
  srxd_idx_t  dec_index;
  srxd_reg_t  dec_reg;
  srxd_pair_t dec_pair;
  srxd_flag_t dec_flags;
  logic       dec_mem_wb;
  logic [2:0] dec_bit;
  logic [7:0] dec_disp;
  logic [7:0] dec_imm;
  logic [3:0] dec_clocks;
  int         err_count = 0;
  int         tests_run = 0;
  int         stall;
  logic       ill;
  srxd_fetch_model i_fetch (.ref_clk(ref_clk), .arst_n(arst_n), .byte_ready(byte_ready),
    .gap(gap), .byte_valid(byte_valid), .byte_data(byte_data));
  srxd_decoder #(.CLK_W(4)) i_dut (.ref_clk(ref_clk), .arst_n(arst_n),
    .byte_valid(byte_valid), .byte_data(byte_data), .byte_ready(byte_ready),
    .dec_valid(dec_valid), .dec_illegal(dec_illegal), .dec_op(dec_op), .dec_opnd(dec_opnd),
    .dec_index(dec_index), .dec_reg(dec_reg), .dec_pair(dec_pair), .dec_flags(dec_flags),
    .dec_mem_wb(dec_mem_wb), .dec_bit(dec_bit), .dec_disp(dec_disp), .dec_imm(dec_imm),
    .dec_clocks(dec_clocks));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // feed bytes, wait for the answer, then count refused cycles
  task automatic issue(input logic [31:0] b, input int n);
    int t;
    t = 0;
    for (int i = n - 1; i >= 0; i--) i_fetch.push(b[8*i+:8]);
    do begin
      @(negedge ref_clk);
      t++;
    end while (dec_valid !== 1'b1 && dec_illegal !== 1'b1 && t < 60);
    chk("answer", 16'h0001, 16'(t < 60));
    ill = dec_illegal;
    stall = 0;
    while (byte_ready === 1'b0 && stall < 20) begin
      stall++;
      @(negedge ref_clk);
    end
  endtask
  task automatic dec(input srxd_op_t op, input srxd_opnd_t od, input srxd_idx_t ix,
                     input int clk, input int n);
    chk("illegal", 16'h0000, 16'(ill));
    chk("op", 16'(op), 16'(dec_op));
    chk("opnd", 16'(od), 16'(dec_opnd));
    chk("index", 16'(ix), 16'(dec_index));
    chk("clocks", 16'(clk), 16'(dec_clocks));
    chk("stall", 16'(clk - n), 16'(stall));
  endtask
  task automatic t_cb_reg();
    logic [4:0] g[5] = '{5'h03, 5'h01, 5'h04, 5'h05, 5'h07};
    srxd_op_t   o[5] = '{OP_ROT_THRU, OP_ROT_CIRC, OP_SHL_ARITH, OP_SHR_ARITH, OP_SHR_LOGIC};
    for (int k = 0; k < 5; k++) for (int r = 0; r < 8; r++) if (r != 6) begin
      issue({16'h0000, 8'hCB, g[k], 3'(r)}, 2);
      dec(o[k], OPND_REG, IDX_NONE, 4, 2);
      chk("reg", 16'(r), 16'(dec_reg));
    end
  endtask
  task automatic t_cb_mem();
    logic [7:0] c[4] = '{8'h0E, 8'h26, 8'h2E, 8'h3E};
    srxd_op_t   o[4] = '{OP_ROT_CIRC, OP_SHL_ARITH, OP_SHR_ARITH, OP_SHR_LOGIC};
    @(posedge ref_clk);
    gap <= 4'h2;
    for (int k = 0; k < 4; k++) begin
      issue({16'h0000, 8'hCB, c[k]}, 2);
      dec(o[k], OPND_MEM_PAIR, IDX_NONE, 10, 2);
      chk("wb", 16'h0001, 16'(dec_mem_wb));
    end
    for (int b = 0; b < 8; b++) begin
      issue({16'h0000, 8'hCB, 2'h3, 3'(b), 3'h6}, 2);
      dec(OP_BIT_SET, OPND_MEM_PAIR, IDX_NONE, 10, 2);
      chk("bit", 16'(b), 16'(dec_bit));
    end
    @(posedge ref_clk);
    gap <= 4'h0;
  endtask
  task automatic t_restart();
    for (int v = 0; v < 8; v++) begin
      issue({24'h0000_00, 2'h3, 3'(v), 3'h7}, 1);
      chk("vec_bad", 16'(!(v inside {2, 3, 4, 5, 7})), 16'(ill));
      if (v inside {2, 3, 4, 5, 7}) begin
        chk("rst_op", 16'(OP_RESTART), 16'(dec_op));
        chk("rst_vec", 16'(v), 16'(dec_bit));
        chk("rst_clk", 16'h0008, 16'(dec_clocks));
      end
      chk("rst_stall", (v inside {2, 3, 4, 5, 7}) ? 16'h0007 : 16'h0000, 16'(stall));
    end
    issue({16'h0000, 8'hCB, 8'h00}, 2);
    chk("cb_other", 16'h0001, 16'(ill));
  endtask
  task automatic t_pair16();
    for (int s = 0; s < 4; s++) begin
      issue({16'h0000, 8'hED, 2'h1, 2'(s), 4'h2}, 2);
      dec(OP_SUB_BORROW16, OPND_PAIR16, IDX_NONE, 4, 2);
      chk("pair", 16'(s), 16'(dec_pair));
      chk("flags16", 16'(FLG_ARITH), 16'(dec_flags));
    end
  endtask
  task automatic t_imm();
    logic [7:0] c[3] = '{8'hDE, 8'hD6, 8'hEE};
    srxd_op_t   o[3] = '{OP_SUB_BORROW, OP_SUB, OP_XOR};
    srxd_flag_t f[3] = '{FLG_ARITH, FLG_ARITH, FLG_LOGIC};
    logic [7:0] s[3] = '{8'h1F, 8'h37, 8'h9F};
    srxd_op_t   so[3] = '{OP_ACC_ROT_THRU, OP_CARRY_ONE, OP_SUB_BORROW};
    srxd_opnd_t sd[3] = '{OPND_NONE, OPND_NONE, OPND_REG};
    for (int k = 0; k < 3; k++) begin
      issue({16'h0000, c[k], 8'hA5 + 8'(k)}, 2);
      dec(o[k], OPND_IMM, IDX_NONE, 4, 2);
      chk("imm", 16'h00A5 + 16'(k), 16'(dec_imm));
      chk("flags", 16'(f[k]), 16'(dec_flags));
    end
    issue({24'h0000_00, 8'h96}, 1);
    dec(OP_SUB, OPND_MEM_PAIR, IDX_NONE, 5, 1);
    for (int k = 0; k < 3; k++) begin
      issue({24'h0000_00, s[k]}, 1);
      dec(so[k], sd[k], IDX_NONE, 2, 1);
    end
  endtask
  task automatic t_indexed();
    logic [7:0] p[2] = '{8'hDD, 8'hFD};
    srxd_idx_t  x[2] = '{IDX_FIRST, IDX_SECOND};
    for (int k = 0; k < 2; k++) begin
      issue({p[k], 8'hCB, 8'h80, 8'h3E}, 4);
      dec(OP_SHR_LOGIC, OPND_INDEXED, x[k], 13, 4);
      chk("disp", 16'h0080, 16'(dec_disp));
      chk("wb_idx", 16'h0001, 16'(dec_mem_wb));
      issue({8'h00, p[k], 8'h96, 8'h7F}, 3);
      dec(OP_SUB, OPND_INDEXED, x[k], 9, 3);
      chk("disp_sub", 16'h007F, 16'(dec_disp));
      issue({8'h00, p[k], 8'hAE, 8'hFF}, 3);
      dec(OP_XOR, OPND_INDEXED, x[k], 9, 3);
      chk("flags_x", 16'(FLG_LOGIC), 16'(dec_flags));
    end
  endtask
  task automatic t_b2b();
    int t;
    t = 0;
    issue({8'hCB, 8'h1D, 8'hDE, 8'h5A}, 4);
    chk("b2b_stall", 16'h0002, 16'(stall));
    while (dec_valid !== 1'b1 && t < 20) begin
      t++;
      @(negedge ref_clk);
    end
    chk("b2b_gap", 16'h0002, 16'(t));
    chk("b2b_imm", 16'h005A, 16'(dec_imm));
    repeat (4) @(negedge ref_clk);
  endtask
  initial begin
    #2_000_000;
    err_count++;
    print_verdict();
  end
  initial begin
    arst_n = 1'b0;
    gap = 4'h0;
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("ready_rst", 16'h0001, 16'(byte_ready));
    chk("valid_rst", 16'h0000, 16'(dec_valid));
    @(posedge ref_clk);
    arst_n <= 1'b1;
    t_cb_reg();
    t_cb_mem();
    t_restart();
    t_pair16();
    t_imm();
    t_indexed();
    t_b2b();
    print_verdict();
  end
endmodule
